// file: ebra_chk.sv
// Concurrent checks on the pins of the external bus controller.
// Assumes it is bound to ebra_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module ebra_chk
(
   // Clock and reset
   input wire logic                        clk,
   input wire logic                        rst,
   // Bus side
   input wire logic                        bus_clock_out,
   input wire logic                        cyc_done,
   input wire logic                        rd_n,
   input wire logic                        wr_n,
   input wire logic [ebra_pkg::NUM_CS-1:0] chip_selects_n,
   input wire logic                        chip_selects_oe_n,
   input wire logic                        other_oe_n,
   // Arbitration
   input wire logic                        hold_n,
   input wire logic                        bus_grant_ack,
   input wire logic                        regain_request_out_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   wire strobes_hi = rd_n & wr_n;
   wire bus_quiet  = strobes_hi & (&chip_selects_n);

   AST_BCLK_TOGGLE: assert property (1 |=> $changed(bus_clock_out))
      else $error("bus clock did not toggle");
   AST_ARB_ON_TICK: assert property ($changed(bus_grant_ack)
      || $changed(regain_request_out_n) |-> $rose(bus_clock_out))
      else $error("arbitration output moved off tick");
   AST_RELEASED: assert property (bus_grant_ack |-> chip_selects_oe_n && other_oe_n
      && (&chip_selects_n)) else $error("bus still driven while granted");
   AST_DRIVE_BACK: assert property ($fell(bus_grant_ack)
      |-> !chip_selects_oe_n && !other_oe_n && regain_request_out_n)
      else $error("drive not resumed on regain");
   AST_GRANT_IDLE: assert property ($rose(bus_grant_ack) |-> $past(bus_quiet))
      else $error("grant inside a running cycle");
   AST_HOLD_SEEN: assert property ($rose(bus_grant_ack) |-> !$past(hold_n, 2))
      else $error("grant without hold request");
   AST_REGAIN_GRANTED: assert property (!regain_request_out_n |-> bus_grant_ack)
      else $error("regain request outside grant");
   AST_REGAIN_LATE: assert property ($fell(regain_request_out_n)
      |-> $past(bus_grant_ack, 3)) else $error("regain request too early");
   AST_HOLD_GONE: assert property ($fell(bus_grant_ack) |-> $past(hold_n, 2))
      else $error("regain while hold still low");
   AST_CMD_ON_TICK: assert property ($fell(rd_n) || $fell(wr_n)
      |-> $rose(bus_clock_out)) else $error("strobe edge off tick");
   AST_CS_WITH_STROBE: assert property (!strobes_hi |-> !(&chip_selects_n))
      else $error("strobe without chip select");
   AST_DONE_END: assert property ($rose(strobes_hi) |-> ##[0:1] cyc_done)
      else $error("cycle end without done");
endmodule

// file: ebra_clkdiv.sv
// Bus clock generator: divides clk into the bus clock output and marks its rising edges.
// Assumes the surrounding logic updates bus signals only on the rise enable pulse.
`timescale 1ns/100ps
module ebra_clkdiv
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Bus clock and rising edge enable
   output logic      bus_clock_out,
   output logic      rise_en
);

   localparam logic [ebra_pkg::HALF_CNT_W-1:0] HALF_LAST =
      ebra_pkg::HALF_CNT_W'(ebra_pkg::HALF_CLOCK_CYCLES - 1);

   logic [ebra_pkg::HALF_CNT_W-1:0] cnt_ff;
   wire                             half_done = (cnt_ff == HALF_LAST);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_ff        <= '0;
         bus_clock_out <= 1'b0;
      end
      else
      begin
         cnt_ff        <= half_done ? '0 : cnt_ff + 1'b1;
         bus_clock_out <= half_done ? ~bus_clock_out : bus_clock_out;
      end
   end

   // High in the cycle before the output rises, so tick logic moves with the rising edge
   assign rise_en = half_done & ~bus_clock_out;

endmodule

// file: ebra_ctrl.sv
// External bus controller: cycle sequencing with ready wait states, and hold/acknowledge arbitration.
// Assumes the CPU side raises one request at a time and that ready and hold come from pins.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps

module ebra_ctrl
(
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               rst,
   // Register port
   input  wire logic [3:0]                         reg_addr,
   input  wire logic [31:0]                        reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic      [31:0]                        reg_rdata,
   // CPU cycle request
   input  wire logic                               cyc_req,
   input  wire logic                               cyc_write,
   input  wire logic [ebra_pkg::CS_SEL_W-1:0]      cyc_cs_sel,
   output logic                                    cyc_busy,
   output logic                                    cyc_done,
   // Bus pins
   output logic                                    bus_clock_out,
   input  wire logic                               ready_n,
   output logic                                    rd_n,
   output logic                                    wr_n,
   output logic      [ebra_pkg::NUM_CS-1:0]        chip_selects_n,
   output logic                                    chip_selects_oe_n,
   output logic                                    other_oe_n,
   // Arbitration pins
   input  wire logic                               hold_n,
   output logic                                    bus_grant_ack,
   output logic                                    regain_request_out_n
);

   // One-hot active-low chip select from an index; out-of-range selects none
   function automatic logic [ebra_pkg::NUM_CS-1:0] cs_decode_n
      (input logic [ebra_pkg::CS_SEL_W-1:0] sel);
      logic [ebra_pkg::NUM_CS-1:0] v;
      v = '1;
      for (int i = 0; i < ebra_pkg::NUM_CS; i++)
      begin
         if (sel == ebra_pkg::CS_SEL_W'(i))
            v[i] = 1'b0;
      end
      return v;
   endfunction

   function automatic logic in_strobe(input ebra_pkg::ebra_state_t s);
      return (s == ebra_pkg::ST_CMD);
   endfunction

   function automatic logic in_cycle(input ebra_pkg::ebra_state_t s);
      return (s == ebra_pkg::ST_ADDR) || (s == ebra_pkg::ST_DELAY) || (s == ebra_pkg::ST_CMD);
   endfunction

   // Bus clock and edge enable
   logic tick;

   ebra_clkdiv u_clkdiv
   (
      .clk           (clk),
      .rst           (rst),
      .bus_clock_out (bus_clock_out),
      .rise_en       (tick)
   );

   // Pin synchronisers; idle level of both active-low pins is high
   logic [1:0] pins_s;

   ebra_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in ({hold_n, ready_n}),
      .sync_out (pins_s)
   );

   wire ready_low_s = ~pins_s[0];
   wire hold_low_s  = ~pins_s[1];

   // Configuration register
   logic [ebra_pkg::CFG_W-1:0] cfg_ff;

   wire                              cfg_wr     = reg_wr & (reg_addr == ebra_pkg::CFG_OFFSET);
   wire [ebra_pkg::CFG_WAIT_W-1:0]   cfg_wait   =
      cfg_ff[ebra_pkg::CFG_WAIT_LSB +: ebra_pkg::CFG_WAIT_W];
   wire                              cfg_rwdly  = cfg_ff[ebra_pkg::CFG_RW_DELAY_BIT];
   wire                              cfg_mux    = cfg_ff[ebra_pkg::CFG_MUX_BIT];
   wire                              cfg_tri    = cfg_ff[ebra_pkg::CFG_TRI_BIT];
   wire                              cfg_rdy_en = cfg_ff[ebra_pkg::CFG_RDY_EN_BIT];
   wire                              cfg_asyn   = cfg_ff[ebra_pkg::CFG_RDY_ASYN_BIT];

   always_ff @(posedge clk)
   begin
      if (rst)
         cfg_ff <= ebra_pkg::CFG_RESET;
      else if (cfg_wr)
         cfg_ff <= reg_wdata[ebra_pkg::CFG_W-1:0];
   end

   // State
   ebra_pkg::ebra_state_t            state_ff;
   ebra_pkg::ebra_state_t            nxt_state;
   logic [ebra_pkg::CFG_WAIT_W-1:0]  wait_cnt_ff;
   logic [ebra_pkg::CFG_WAIT_W-1:0]  nxt_wait_cnt;
   logic                             pending_ff;
   logic                             pend_write_ff;
   logic [ebra_pkg::CS_SEL_W-1:0]    pend_cs_ff;
   logic                             grant_age_ff;
   logic                             ready_late_ff;

   // Asynchronous mode pays one more bus clock of synchronisation before acting
   wire ready_seen = cfg_asyn ? ready_late_ff : ready_low_s;
   wire cyc_end    = tick && (state_ff == ebra_pkg::ST_CMD) && (wait_cnt_ff == '0)
                     && (!cfg_rdy_en || ready_seen);
   wire start_ok   = pending_ff && !hold_low_s;
   wire accept     = cyc_req && !pending_ff;

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_wait_cnt = wait_cnt_ff;
      unique case (state_ff)
         ebra_pkg::ST_IDLE:
         begin
            if (hold_low_s)
               nxt_state = ebra_pkg::ST_GRANT;
            else if (start_ok)
               nxt_state = ebra_pkg::ST_ADDR;
         end
         ebra_pkg::ST_ADDR:
         begin
            nxt_wait_cnt = cfg_wait;
            nxt_state    = cfg_rwdly ? ebra_pkg::ST_DELAY : ebra_pkg::ST_CMD;
         end
         ebra_pkg::ST_DELAY:
            nxt_state = ebra_pkg::ST_CMD;
         ebra_pkg::ST_CMD:
         begin
            if (wait_cnt_ff != '0)
               nxt_wait_cnt = wait_cnt_ff - 1'b1;
            else if (cfg_rdy_en && !ready_seen)
               nxt_state = ebra_pkg::ST_CMD;
            else if (cfg_mux)
               nxt_state = ebra_pkg::ST_MUX_WAIT;
            else if (cfg_tri)
               nxt_state = ebra_pkg::ST_TRI_WAIT;
            else
               nxt_state = ebra_pkg::ST_IDLE;
         end
         ebra_pkg::ST_MUX_WAIT:
            nxt_state = cfg_tri ? ebra_pkg::ST_TRI_WAIT : ebra_pkg::ST_IDLE;
         ebra_pkg::ST_TRI_WAIT:
            nxt_state = ebra_pkg::ST_IDLE;
         ebra_pkg::ST_GRANT:
         begin
            // Only the rising hold level starts the regain, whatever the request did
            if (!hold_low_s)
               nxt_state = ebra_pkg::ST_REGAIN;
         end
         ebra_pkg::ST_REGAIN:
            nxt_state = ebra_pkg::ST_IDLE;
         default:
            nxt_state = ebra_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff    <= ebra_pkg::ST_IDLE;
         wait_cnt_ff <= '0;
      end
      else if (tick)
      begin
         state_ff    <= nxt_state;
         wait_cnt_ff <= nxt_wait_cnt;
      end
   end

   // Extra ready stage on bus clock edges for asynchronous mode
   always_ff @(posedge clk)
   begin
      if (rst)
         ready_late_ff <= 1'b0;
      else if (tick)
         ready_late_ff <= in_strobe(state_ff) && ready_low_s;
   end

   // Pending CPU request; a new request is taken only when none is pending
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pending_ff    <= 1'b0;
         pend_write_ff <= 1'b0;
         pend_cs_ff    <= '0;
      end
      else if (accept)
      begin
         pending_ff    <= 1'b1;
         pend_write_ff <= cyc_write;
         pend_cs_ff    <= cyc_cs_sel;
      end
      else if (cyc_end)
         pending_ff <= 1'b0;
   end

   // Grant age: regain request is held off for the first two bus clocks of the grant
   always_ff @(posedge clk)
   begin
      if (rst)
         grant_age_ff <= 1'b0;
      else if (tick)
         grant_age_ff <= (state_ff == ebra_pkg::ST_GRANT);
   end

   // Pin outputs, all updated on the bus clock rising edge
   wire                         granted_nxt = (nxt_state == ebra_pkg::ST_GRANT);
   wire                         strobe_nxt  = in_strobe(nxt_state);
   wire [ebra_pkg::NUM_CS-1:0]  cs_nxt      =
      in_cycle(nxt_state) ? cs_decode_n(pend_cs_ff) : '1;
   wire                         regain_nxt  =
      (state_ff == ebra_pkg::ST_GRANT) && grant_age_ff && pending_ff && hold_low_s;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_n                 <= 1'b1;
         wr_n                 <= 1'b1;
         chip_selects_n       <= '1;
         chip_selects_oe_n    <= 1'b0;
         other_oe_n           <= 1'b0;
         bus_grant_ack        <= 1'b0;
         regain_request_out_n <= 1'b1;
      end
      else if (tick)
      begin
         rd_n                 <= ~(strobe_nxt & ~pend_write_ff);
         wr_n                 <= ~(strobe_nxt & pend_write_ff);
         chip_selects_n       <= cs_nxt;
         // Released pins float; the board pull-ups keep chip selects high
         chip_selects_oe_n    <= granted_nxt;
         other_oe_n           <= granted_nxt;
         bus_grant_ack        <= granted_nxt;
         regain_request_out_n <= ~(regain_nxt && granted_nxt);
      end
   end

   // CPU side status
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cyc_busy <= 1'b0;
         cyc_done <= 1'b0;
      end
      else
      begin
         cyc_busy <= (pending_ff & ~cyc_end) | accept;
         cyc_done <= cyc_end;
      end
   end

   // Register read, data valid the cycle after the strobe only
   wire [31:0] status_word =
      {28'h0000000,
       ~regain_request_out_n,
       pending_ff,
       bus_grant_ack,
       (state_ff != ebra_pkg::ST_IDLE)};
   wire [31:0] rd_mux =
      (reg_addr == ebra_pkg::CFG_OFFSET)    ? {23'h000000, cfg_ff} :
      (reg_addr == ebra_pkg::STATUS_OFFSET) ? status_word : 32'h00000000;

   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= 32'h00000000;
      else
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
   end

endmodule

// file: ebra_ctrl_bench.sv
// Self-checking bench: register port, cycle sizing, ready waits and arbitration.
// Assumes ebra_partner answers ready and drives hold; checker is bound below.
`timescale 1ns/100ps
module ebra_ctrl_bench;
   logic        clk, rst, reg_wr, reg_rd, cyc_req, cyc_write, hold_req, chain;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [2:0]  cyc_cs_sel;
   logic [7:0]  lat;
   logic        cyc_busy, cyc_done, bus_clock_out, ready_n, rd_n, wr_n, hold_n;
   logic        cs_oe_n, other_oe_n, bus_grant_ack, regain_request_out_n;
   logic [4:0]  chip_selects_n;
   int          err_total, samples_checked, tcnt, lo0, lo, su, pre, p0, l1, i;
   int          gc [3] = '{32'h0, 32'h20, 32'h60};
   int          ge [3] = '{0, 2, 4};

   ebra_ctrl ebra_ctrl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_req(cyc_req),
      .cyc_write(cyc_write), .cyc_cs_sel(cyc_cs_sel), .cyc_busy(cyc_busy),
      .cyc_done(cyc_done), .bus_clock_out(bus_clock_out), .ready_n(ready_n), .rd_n(rd_n),
      .wr_n(wr_n), .chip_selects_n(chip_selects_n), .chip_selects_oe_n(cs_oe_n),
      .other_oe_n(other_oe_n), .hold_n(hold_n), .bus_grant_ack(bus_grant_ack),
      .regain_request_out_n(regain_request_out_n));
   ebra_partner ebra_partner_i (.clk(clk), .lat(lat), .hold_req(hold_req), .rd_n(rd_n),
      .wr_n(wr_n), .ready_n(ready_n), .hold_n(hold_n));

   always #5 clk = ~clk;

   task results();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask

   // Counts clk cycles: before chip select, chip select before strobe, strobe low
   task automatic cyc(input logic w, output int l, output int s, output int p);
      int         n;
      logic       st;
      logic [4:0] csl;
      logic [4:0] cse;
      cyc_req   <= 1'b1;
      cyc_write <= w;
      @(posedge clk);
      // A chained caller keeps the request up so it is taken as this cycle ends
      cyc_req <= chain;
      l = 0;
      s = 0;
      p = 0;
      n = 0;
      csl = 5'h1f;
      while (cyc_done !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         n++;
         st = w ? wr_n : rd_n;
         if (chip_selects_n !== 5'h1f) csl = chip_selects_n;
         if (st === 1'b0) l++;
         else if (chip_selects_n !== 5'h1f) s++;
         else if (l == 0) p++;
      end
      check(cyc_done, 1'b1);
      cse = ~(5'h01 << cyc_cs_sel);
      check(csl, cse);
   endtask

   always @(posedge clk)
   begin
      tcnt <= tcnt + 1;
      if (tcnt == 30000)
      begin
         err_total++;
         results();
      end
   end

   initial
   begin
      clk = 0; rst = 1; reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 0; reg_rd = 0;
      cyc_req = 0; cyc_write = 0; cyc_cs_sel = 3'h2; lat = 8'h04; hold_req = 0;
      err_total = 0; samples_checked = 0; tcnt = 0; chain = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(ebra_pkg::CFG_OFFSET, d);
      check(d, 32'h0);
      wr(ebra_pkg::CFG_OFFSET, 32'hffffffff);
      rd(ebra_pkg::CFG_OFFSET, d);
      check(d, 32'h1ff);
      rd(4'h8, d);
      check(d, 32'h0);
      wr(ebra_pkg::CFG_OFFSET, 32'h0);
      rd(ebra_pkg::STATUS_OFFSET, d);
      check(d, 32'h0);
      cyc(1'b0, lo0, su, pre);
      check(su, 2);
      cyc(1'b1, lo, su, pre);
      check(lo, lo0);
      wr(ebra_pkg::CFG_OFFSET, 32'h10);
      cyc(1'b0, lo, su, pre);
      check(su, 4);
      wr(ebra_pkg::CFG_OFFSET, 32'h3);
      cyc(1'b1, lo, su, pre);
      check(lo - lo0, 6);
      cyc_cs_sel <= 3'h4;
      for (i = 0; i < 3; i++)
      begin
         wr(ebra_pkg::CFG_OFFSET, gc[i]);
         chain = 1'b1;
         cyc(1'b0, lo, su, pre);
         chain = 1'b0;
         cyc(1'b0, lo, su, pre);
         if (i == 0) p0 = pre;
         check(pre - p0, ge[i]);
      end
      wr(ebra_pkg::CFG_OFFSET, 32'h80);
      lat <= 8'd20;
      cyc(1'b0, l1, su, pre);
      check(l1 >= 20, 1'b1);
      lat <= 8'd40;
      cyc(1'b1, lo, su, pre);
      check(lo - l1, 20);
      wr(ebra_pkg::CFG_OFFSET, 32'h180);
      lat <= 8'd20;
      cyc(1'b0, lo, su, pre);
      check(lo - l1, 2);
      wr(ebra_pkg::CFG_OFFSET, 32'h80);
      lat <= 8'd40;
      fork
         cyc(1'b0, lo, su, pre);
         begin
            repeat (8) @(posedge clk);
            hold_req <= 1'b1;
         end
      join
      for (i = 0; i < 100 && bus_grant_ack !== 1'b1; i++) @(posedge clk);
      check(bus_grant_ack, 1'b1);
      check({cs_oe_n, other_oe_n}, 2'b11);
      fork
         cyc(1'b1, lo, su, pre);
         begin
            repeat (20) @(posedge clk);
            check(regain_request_out_n, 1'b0);
            check({cyc_busy, chip_selects_n}, 6'h3f);
            rd(ebra_pkg::STATUS_OFFSET, d);
            check(d & 32'he, 32'he);
            hold_req <= 1'b0;
         end
      join
      check(bus_grant_ack, 1'b0);
      hold_req <= 1'b1;
      repeat (20) @(posedge clk);
      check({bus_grant_ack, regain_request_out_n}, 2'b11);
      hold_req <= 1'b0;
      repeat (20) @(posedge clk);
      check({bus_grant_ack, cs_oe_n}, 2'b00);
      results();
   end
endmodule

bind ebra_ctrl ebra_chk ebra_chk_i (.clk(clk), .rst(rst), .bus_clock_out(bus_clock_out),
   .cyc_done(cyc_done), .rd_n(rd_n), .wr_n(wr_n), .chip_selects_n(chip_selects_n),
   .chip_selects_oe_n(chip_selects_oe_n), .other_oe_n(other_oe_n), .hold_n(hold_n),
   .bus_grant_ack(bus_grant_ack), .regain_request_out_n(regain_request_out_n));

// file: ebra_partner.sv
// External memory answering with ready, and an external master asking for hold.
// Assumes strobes are sampled on clk; ready line has a pull-up when not driven.
`timescale 1ns/100ps
module ebra_partner
(
   // Clock
   input wire logic       clk,
   // Bench controls
   input wire logic [7:0] lat,
   input wire logic       hold_req,
   // Pins
   input wire logic       rd_n,
   input wire logic       wr_n,
   output logic           ready_n,
   output logic           hold_n
);
   logic [7:0] cnt_ff;
   wire        cmd_on = !(rd_n && wr_n);

   initial
   begin
      cnt_ff = 8'h00;
      hold_n = 1'b1;
   end
   always @(posedge clk)
   begin
      cnt_ff <= cmd_on ? ((cnt_ff == 8'hff) ? cnt_ff : cnt_ff + 8'h01) : 8'h00;
      hold_n <= !hold_req;
   end
   // Ready held until the strobe rises, far longer than the minimum low time
   assign ready_n = !(cmd_on && cnt_ff >= lat);
endmodule

// file: ebra_pkg.sv
// Constants, field layouts and state encoding for the external bus ready and arbitration block.
// Assumes a single 100 MHz system clock; every bus-side rate is derived from it.
package ebra_pkg;

   // Clocking: one bus clock half period equals one system clock period here
   localparam int unsigned CLK_PERIOD_NS         = 10;
   localparam int unsigned HALF_CLOCK_PERIOD_NS  = 10;
   localparam int unsigned HALF_CLOCK_CYCLES     =
      (HALF_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HALF_CNT_W            = 4;

   // Register offsets (byte addresses)
   localparam logic [3:0] CFG_OFFSET    = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;

   // Configuration field positions
   localparam int unsigned CFG_WAIT_LSB     = 0;
   localparam int unsigned CFG_WAIT_W       = 4;
   localparam int unsigned CFG_RW_DELAY_BIT = 4;
   localparam int unsigned CFG_MUX_BIT      = 5;
   localparam int unsigned CFG_TRI_BIT      = 6;
   localparam int unsigned CFG_RDY_EN_BIT   = 7;
   localparam int unsigned CFG_RDY_ASYN_BIT = 8;
   localparam int unsigned CFG_W            = 9;
   localparam logic [8:0]  CFG_RESET        = 9'h000;

   // Status field positions
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_GRANTED_BIT = 1;
   localparam int unsigned ST_PENDING_BIT = 2;
   localparam int unsigned ST_REGAIN_BIT  = 3;

   localparam int unsigned NUM_CS = 5;
   localparam int unsigned CS_SEL_W = 3;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DELAY,
      ST_CMD,
      ST_MUX_WAIT,
      ST_TRI_WAIT,
      ST_GRANT,
      ST_REGAIN
   } ebra_state_t;

endpackage

// file: ebra_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/100ps
module ebra_sync
#(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Pins in, synchronised out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_ff;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage1_ff <= RESET_VAL;
         sync_out  <= RESET_VAL;
      end
      else
      begin
         stage1_ff <= async_in;
         sync_out  <= stage1_ff;
      end
   end

endmodule
